// ### hdl/fault_channel.sv
// One channel's fault state machine, restart timer and drive gating
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module fault_channel #(
	parameter int unsigned RESTART_CYCLES = fault_pkg::RESTART_CYCLES
) (
	input  wire logic        pclk,          // Core clock
	input  wire logic        presetn,       // Async reset, active low
	input  wire logic        global_ok,     // Bias good, awake, software run
	input  wire logic        chan_en,       // Software channel enable
	input  wire logic        over_temp,     // Junction above trip level
	input  wire logic        dropout,       // Dim input below dropout level
	input  wire logic        input_uv,      // Dim input below enable level
	input  wire logic        boot_uv_fall,  // Bootstrap below lower level
	input  wire logic        boot_uv_rise,  // Bootstrap below upper level
	input  wire logic        comp_ov,       // Compensation overvoltage
	input  wire logic        comp_start,    // Compensation above start level
	input  wire logic        short_out,     // Sense node below short level
	input  wire logic        hs_oc,         // High-side overcurrent
	input  wire logic        ls_oc,         // Low-side overcurrent
	output logic             hs_on,         // High-side gate allowed
	output logic             ls_on,         // Low-side gate allowed
	output logic             amp_en,        // Error amplifier enabled
	output logic             comp_connect,  // Compensation network connected
	output logic             comp_discharge,// Discharge compensation capacitor
	output logic             fault_o,       // Fault flag open-drain output data
	output logic             fault_oe_n,    // Fault flag enable, low drives
	output fault_pkg::chan_state_t state    // Current state
);

	fault_pkg::chan_state_t next_state;
	logic [fault_pkg::TIMER_W-1:0] timer;
	logic timer_done;

	assign timer_done = (timer == '0);

	// ****************************************************************
	// State transitions, one machine per channel
	// ****************************************************************
	always_comb begin
		next_state = state;
		case (state)
			fault_pkg::ST_OFF: begin
				if (global_ok && chan_en && !over_temp)
					next_state = fault_pkg::ST_SOFT;
			end
			fault_pkg::ST_SOFT: begin
				if (comp_start)
					next_state = fault_pkg::ST_RUN;
			end
			fault_pkg::ST_RUN: begin
				if (boot_uv_fall)
					next_state = fault_pkg::ST_BOOT_UV;
			end
			fault_pkg::ST_BOOT_UV: begin
				if (!boot_uv_rise)
					next_state = fault_pkg::ST_RUN;
			end
			fault_pkg::ST_HS_LIM, fault_pkg::ST_LS_LIM: begin
				if (timer_done)
					next_state = fault_pkg::ST_SOFT;
			end
			fault_pkg::ST_THERMAL: begin
				if (!over_temp)
					next_state = fault_pkg::ST_SOFT;
			end
			default: next_state = fault_pkg::ST_OFF;
		endcase
		// Current limits override the run states; low side is the harsher
		if (state == fault_pkg::ST_RUN || state == fault_pkg::ST_BOOT_UV || state == fault_pkg::ST_SOFT) begin
			if (ls_oc)
				next_state = fault_pkg::ST_LS_LIM;
			else if (hs_oc)
				next_state = fault_pkg::ST_HS_LIM;
		end
		if (over_temp && state != fault_pkg::ST_OFF)
			next_state = fault_pkg::ST_THERMAL;
		if (!global_ok || !chan_en)
			next_state = fault_pkg::ST_OFF;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= fault_pkg::ST_OFF;
		else
			state <= next_state;
	end

	// Restart timer, loaded on entry to a current-limit fault
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			timer <= '0;
		else if ((next_state == fault_pkg::ST_HS_LIM || next_state == fault_pkg::ST_LS_LIM) &&
		         state != next_state)
			timer <= fault_pkg::TIMER_W'(RESTART_CYCLES - 1);
		else if (!timer_done)
			timer <= timer - 1'b1;
	end

	// ****************************************************************
	// Drive outputs, registered
	// ****************************************************************
	// Input undervoltage gates switching without leaving run, so that
	// recovery resumes at the held compensation level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hs_on          <= 1'b0;
			ls_on          <= 1'b0;
			amp_en         <= 1'b0;
			comp_connect   <= 1'b0;
			comp_discharge <= 1'b1;
		end else begin
			hs_on          <= 1'b0;
			ls_on          <= 1'b0;
			amp_en         <= 1'b0;
			comp_connect   <= 1'b0;
			comp_discharge <= 1'b0;
			case (next_state)
				fault_pkg::ST_RUN: begin
					hs_on        <= !input_uv;
					ls_on        <= !input_uv;
					amp_en       <= !dropout && !input_uv;
					comp_connect <= !dropout && !input_uv;
				end
				fault_pkg::ST_SOFT: begin
					amp_en       <= !dropout && !input_uv;
					comp_connect <= !dropout && !input_uv;
				end
				fault_pkg::ST_BOOT_UV: begin
					ls_on        <= !input_uv;
					amp_en       <= !dropout && !input_uv;
					comp_connect <= !dropout && !input_uv;
				end
				fault_pkg::ST_HS_LIM: begin
					ls_on          <= !input_uv;
					comp_discharge <= 1'b1;
				end
				fault_pkg::ST_LS_LIM: begin
					comp_discharge <= 1'b1;
				end
				fault_pkg::ST_THERMAL: begin
					comp_discharge <= 1'b1;
				end
				default: begin
					comp_discharge <= 1'b1;
				end
			endcase
		end
	end

	// Open-drain fault flag: low whenever open or short is seen
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_oe_n <= 1'b1;
		else
			fault_oe_n <= !(comp_ov || short_out);
	end

	assign fault_o = 1'b0;

endmodule

`default_nettype wire

// ### hdl/fault_pkg.sv
// Package of constants for the LED driver fault manager
package fault_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned CLK_FREQ_HZ        = 250_000_000;
	localparam int unsigned RESTART_DELAY_US   = 3600;
	localparam int unsigned RESTART_CYCLES     = RESTART_DELAY_US * (CLK_FREQ_HZ / 1_000_000);
	localparam int unsigned TIMER_W            = 20;

	// ****************************************************************
	// Register map (APB byte offsets)
	// ****************************************************************
	localparam logic [11:0] ADDR_CONTROL       = 12'h000;
	localparam logic [11:0] ADDR_STATUS0       = 12'h004;
	localparam logic [11:0] ADDR_STATUS1       = 12'h008;
	localparam logic [11:0] ADDR_ID            = 12'h00C;

	// Control fields
	localparam int unsigned CTRL_RUN_BIT       = 0;
	localparam int unsigned CTRL_CH0_EN_BIT    = 1;
	localparam int unsigned CTRL_CH1_EN_BIT    = 2;
	localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK          = 32'h0000_0007;

	// Identification word, value arbitrary
	localparam logic [31:0] BLOCK_ID           = 32'h0051_0001;

	// ****************************************************************
	// Channel states
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_OFF      = 3'b000,
		ST_SOFT     = 3'b001,
		ST_RUN      = 3'b010,
		ST_BOOT_UV  = 3'b011,
		ST_HS_LIM   = 3'b100,
		ST_LS_LIM   = 3'b101,
		ST_THERMAL  = 3'b110
	} chan_state_t;

endpackage

// ### hdl/led_driver_fault_manager.sv
// Top of the dual-channel LED driver fault manager with APB registers
`timescale 1ns/1ps
`default_nettype none

module led_driver_fault_manager #(
	parameter int unsigned RESTART_CYCLES = fault_pkg::RESTART_CYCLES // Restart delay in cycles
) (
	input  wire logic        pclk,                    // APB and core clock
	input  wire logic        presetn,                 // Async reset, active low
	input  wire logic        psel,                    // APB select
	input  wire logic        penable,                 // APB enable
	input  wire logic        pwrite,                  // APB write
	input  wire logic [11:0] paddr,                   // APB byte address
	input  wire logic [31:0] pwdata,                  // APB write data
	output logic      [31:0] prdata,                  // APB read data
	output logic             pready,                  // APB ready
	output logic             pslverr,                 // APB error
	input  wire logic        digital_bias_supply_good,// Digital bias above threshold
	input  wire logic        analog_bias_supply_good, // Analog bias above threshold
	input  wire logic        sleep_req,               // Device sleep state
	output logic             analog_bias_connect,     // Internal analog bias switch
	input  wire logic [1:0]  over_temp,               // Per channel thermal trip
	input  wire logic [1:0]  dim_dropout,             // Dim input below dropout level
	input  wire logic [1:0]  dim_undervoltage,        // Dim input below enable level
	input  wire logic [1:0]  boot_uv_fall,            // Bootstrap below falling level
	input  wire logic [1:0]  boot_uv_rise,            // Bootstrap below rising level
	input  wire logic [1:0]  comp_ov,                 // Compensation overvoltage
	input  wire logic [1:0]  comp_start,              // Compensation above start level
	input  wire logic [1:0]  sense_short,             // Sense node below short level
	input  wire logic [1:0]  hs_overcurrent,          // High-side current limit
	input  wire logic [1:0]  ls_overcurrent,          // Low-side current limit
	output logic      [1:0]  hs_gate_en,              // High-side drive allowed
	output logic      [1:0]  ls_gate_en,              // Low-side drive allowed
	output logic      [1:0]  amp_en,                  // Error amplifier enable
	output logic      [1:0]  comp_connect,            // Compensation network connect
	output logic      [1:0]  comp_discharge,          // Compensation discharge
	output logic      [1:0]  channel_fault_flag_n_o,  // Fault flag output data
	output logic      [1:0]  channel_fault_flag_n_oe_n// Fault flag enable, low drives
);

	// ****************************************************************
	// Shared enables
	// ****************************************************************
	logic [31:0] control;
	logic        global_ok;
	logic [31:0] next_prdata;
	fault_pkg::chan_state_t ch_state [2];

	// Either bias dropping or sleep stops both channels together
	assign global_ok = digital_bias_supply_good && analog_bias_supply_good &&
	                   !sleep_req && control[fault_pkg::CTRL_RUN_BIT];

	// Analog bias is opened in sleep to save current
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			analog_bias_connect <= 1'b0;
		else
			analog_bias_connect <= !sleep_req;
	end

	// ****************************************************************
	// Channels
	// ****************************************************************
	for (genvar i = 0; i < 2; i++) begin : g_ch
		fault_channel #(
			.RESTART_CYCLES(RESTART_CYCLES)
		) u_ch (
			.pclk          (pclk),
			.presetn       (presetn),
			.global_ok     (global_ok),
			.chan_en       (control[fault_pkg::CTRL_CH0_EN_BIT + i]),
			.over_temp     (over_temp[i]),
			.dropout       (dim_dropout[i]),
			.input_uv      (dim_undervoltage[i]),
			.boot_uv_fall  (boot_uv_fall[i]),
			.boot_uv_rise  (boot_uv_rise[i]),
			.comp_ov       (comp_ov[i]),
			.comp_start    (comp_start[i]),
			.short_out     (sense_short[i]),
			.hs_oc         (hs_overcurrent[i]),
			.ls_oc         (ls_overcurrent[i]),
			.hs_on         (hs_gate_en[i]),
			.ls_on         (ls_gate_en[i]),
			.amp_en        (amp_en[i]),
			.comp_connect  (comp_connect[i]),
			.comp_discharge(comp_discharge[i]),
			.fault_o       (channel_fault_flag_n_o[i]),
			.fault_oe_n    (channel_fault_flag_n_oe_n[i]),
			.state         (ch_state[i])
		);
	end

	// ****************************************************************
	// APB slave, zero wait states
	// ****************************************************************
	assign pready  = 1'b1;
	assign pslverr = 1'b0;

	// Control register write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			control <= fault_pkg::CTRL_RESET;
		else if (psel && penable && pwrite && paddr == fault_pkg::ADDR_CONTROL)
			control <= pwdata & fault_pkg::CTRL_MASK;
	end

	// Status word: live comparator view plus channel state
	function automatic logic [31:0] status_word(input fault_pkg::chan_state_t st, input int i);
		status_word = {16'h0000,
		               comp_ov[i], sense_short[i], over_temp[i], hs_overcurrent[i],
		               ls_overcurrent[i], boot_uv_fall[i], dim_undervoltage[i], dim_dropout[i],
		               hs_gate_en[i], ls_gate_en[i], amp_en[i], comp_discharge[i],
		               !channel_fault_flag_n_oe_n[i], st};
	endfunction

	// Read mux, sampled at setup so data stands in the access phase
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			fault_pkg::ADDR_CONTROL: next_prdata = control;
			fault_pkg::ADDR_STATUS0: next_prdata = status_word(ch_state[0], 0);
			fault_pkg::ADDR_STATUS1: next_prdata = status_word(ch_state[1], 1);
			fault_pkg::ADDR_ID:      next_prdata = fault_pkg::BLOCK_ID;
			default:                 next_prdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			prdata <= next_prdata;
	end

endmodule

`default_nettype wire

// ### verification/fault_manager_monitor.sv
// Checker of the fault manager's port behaviour
`timescale 1ns/1ps
`default_nettype none

module fault_manager_monitor (
	input wire logic       pclk,                      // Clock
	input wire logic       presetn,                   // Reset, active low
	input wire logic       psel,                      // APB select
	input wire logic       penable,                   // APB enable
	input wire logic       pready,                    // APB ready
	input wire logic       pslverr,                   // APB error
	input wire logic       digital_bias_supply_good,  // Digital bias good
	input wire logic       sleep_req,                 // Sleep state
	input wire logic       analog_bias_connect,       // Analog bias switch
	input wire logic [1:0] over_temp,                 // Thermal trip
	input wire logic [1:0] dim_dropout,               // Dropout
	input wire logic [1:0] dim_undervoltage,          // Input undervoltage
	input wire logic [1:0] boot_uv_fall,              // Bootstrap low
	input wire logic [1:0] comp_ov,                   // Compensation high
	input wire logic [1:0] sense_short,               // Output short
	input wire logic [1:0] hs_overcurrent,            // High-side limit
	input wire logic [1:0] ls_overcurrent,            // Low-side limit
	input wire logic [1:0] hs_gate_en,                // High-side drive
	input wire logic [1:0] ls_gate_en,                // Low-side drive
	input wire logic [1:0] amp_en,                    // Amplifier enable
	input wire logic [1:0] comp_connect,              // Compensation connect
	input wire logic [1:0] comp_discharge,            // Compensation discharge
	input wire logic [1:0] channel_fault_flag_n_o,    // Flag data
	input wire logic [1:0] channel_fault_flag_n_oe_n  // Flag enable
);
	// ****************************************************************
	// Protection responses
	// ****************************************************************
	// Level causes get three cycles, though outputs register next_state and so follow one edge after the cause
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_thermal_off: assert property (over_temp[1] [*3] |-> !hs_gate_en[1] && !ls_gate_en[1])
		else $error("thermal channel still switching");
	a_bias_lockout: assert property (!digital_bias_supply_good [*3] |-> {hs_gate_en, ls_gate_en} == 4'h0 && comp_discharge == 2'h3)
		else $error("lockout did not stop both channels");
	a_sleep_stop: assert property (sleep_req [*3] |-> !analog_bias_connect && hs_gate_en == 2'h0 && comp_discharge == 2'h3)
		else $error("sleep did not stop the device");
	a_dropout_amp: assert property (dim_dropout[0] [*3] |-> !amp_en[0] && !comp_connect[0])
		else $error("dropout left amplifier connected");
	a_uv_stop: assert property (dim_undervoltage[1] [*3] |-> !hs_gate_en[1] && !ls_gate_en[1])
		else $error("undervoltage channel still switching");
	a_boot_hs_off: assert property (boot_uv_fall[0] [*3] |-> !hs_gate_en[0])
		else $error("high side on with bootstrap low");
	a_hs_limit: assert property ($rose(hs_overcurrent[0]) |-> ##2 !hs_gate_en[0] && comp_discharge[0])
		else $error("high-side limit response missing");
	a_ls_limit: assert property ($rose(ls_overcurrent[1]) |-> ##2 !hs_gate_en[1] && !ls_gate_en[1] && comp_discharge[1])
		else $error("low-side limit response missing");
	a_flag_set: assert property (comp_ov[0] || sense_short[0] |=> !channel_fault_flag_n_oe_n[0] && !channel_fault_flag_n_o[0])
		else $error("fault flag not driven low");
	a_flag_clear: assert property (!comp_ov[1] && !sense_short[1] |=> channel_fault_flag_n_oe_n[1])
		else $error("fault flag driven without cause");
	a_apb_nowait: assert property (psel && penable |-> pready && !pslverr)
		else $error("bus access stalled or refused");
endmodule

bind led_driver_fault_manager fault_manager_monitor i_fault_manager_monitor (.*);
`default_nettype wire

// ### verification/power_stage_model.sv
// Comparator levels of the power stage and the pulled-up fault pins
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
	input wire logic       pclk,                      // Clock
	input wire logic [1:0] channel_fault_flag_n_o,    // Flag data
	input wire logic [1:0] channel_fault_flag_n_oe_n, // Flag enable
	output logic     [1:0] over_temp,                 // Comparator levels
	output logic     [1:0] dim_dropout,
	output logic     [1:0] dim_undervoltage,
	output logic     [1:0] boot_uv_fall,
	output logic     [1:0] boot_uv_rise,
	output logic     [1:0] comp_ov,
	output logic     [1:0] comp_start,
	output logic     [1:0] sense_short,
	output logic     [1:0] hs_overcurrent,
	output logic     [1:0] ls_overcurrent,
	output logic     [1:0] fault_pin                  // Pin level seen by the host
);
	logic [9:0][1:0] lvl;
	initial lvl = '0;
	// One level per comparator, indexed in port order
	assign {ls_overcurrent, hs_overcurrent, sense_short, comp_start, comp_ov} = lvl[9:5];
	assign {boot_uv_rise, boot_uv_fall, dim_undervoltage, dim_dropout, over_temp} = lvl[4:0];
	// External pull-up: a released pin reads high, never the last driven value
	assign fault_pin[0] = channel_fault_flag_n_oe_n[0] ? 1'b1 : channel_fault_flag_n_o[0];
	assign fault_pin[1] = channel_fault_flag_n_oe_n[1] ? 1'b1 : channel_fault_flag_n_o[1];
	// Comparators change just after a clock edge, like synchronised inputs
	task automatic set(input int idx, input int ch, input logic v);
		@(posedge pclk);
		lvl[idx][ch] <= v;
	endtask
endmodule
`default_nettype wire

// ### verification/led_driver_fault_manager_tb.sv
// Self-checking testbench of the fault manager
`timescale 1ns/1ps
`default_nettype none

module led_driver_fault_manager_tb;
	localparam int RC = 20;
	localparam int OT = 0, DO = 1, UV = 2, BF = 3, BR = 4, OV = 5, CS = 6, SH = 7, HO = 8, LO = 9;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_req, analog_bias_connect;
	logic        digital_bias_supply_good, analog_bias_supply_good;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0]  over_temp, dim_dropout, dim_undervoltage, boot_uv_fall, boot_uv_rise, comp_ov, comp_start;
	logic [1:0]  sense_short, hs_overcurrent, ls_overcurrent, hs_gate_en, ls_gate_en, amp_en, comp_connect;
	logic [1:0]  comp_discharge, channel_fault_flag_n_o, channel_fault_flag_n_oe_n, fault_pin;
	int          fail_count, comparisons;

	led_driver_fault_manager #(.RESTART_CYCLES(RC)) i_led_driver_fault_manager (.*);
	power_stage_model i_power_stage_model (.*);

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer; the idle edge first keeps back-to-back calls apart
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fail_count++;
			give_verdict();
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Sample on the falling edge, where registered outputs have settled
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		@(negedge pclk);
	endtask
	task automatic gates(input logic [3:0] exp);
		chk({hs_gate_en, ls_gate_en}, exp);
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_regs();
		apb(1'b0, fault_pkg::ADDR_ID, 32'h0000_0000, rd);
		chk(rd, fault_pkg::BLOCK_ID);
		apb(1'b1, 12'h010, 32'hFFFF_FFFF, rd);
		apb(1'b0, 12'h010, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		apb(1'b0, fault_pkg::ADDR_CONTROL, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		apb(1'b1, fault_pkg::ADDR_CONTROL, 32'h0000_0007, rd);
		apb(1'b0, fault_pkg::ADDR_CONTROL, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0007);
		wt(5);
		gates(4'h0);
		chk(amp_en, 2'h3);
		i_power_stage_model.set(CS, 0, 1'b1);
		i_power_stage_model.set(CS, 1, 1'b1);
		wt(4);
		gates(4'hF);
		chk({amp_en, comp_connect, comp_discharge, analog_bias_connect}, 7'h79);
	endtask
	task automatic t_input_levels();
		i_power_stage_model.set(DO, 0, 1'b1);
		wt(4);
		chk({amp_en, comp_connect, hs_gate_en}, 6'h2B);
		i_power_stage_model.set(DO, 0, 1'b0);
		i_power_stage_model.set(UV, 1, 1'b1);
		wt(4);
		chk(amp_en, 2'h1);
		gates(4'h5);
		i_power_stage_model.set(UV, 1, 1'b0);
		wt(4);
		gates(4'hF);
	endtask
	task automatic t_bootstrap();
		i_power_stage_model.set(BF, 0, 1'b1);
		i_power_stage_model.set(BR, 0, 1'b1);
		wt(4);
		gates(4'hB);
		i_power_stage_model.set(BF, 0, 1'b0);
		wt(4);
		gates(4'hB);
		i_power_stage_model.set(BR, 0, 1'b0);
		wt(4);
		gates(4'hF);
	endtask
	task automatic t_limits();
		i_power_stage_model.set(HO, 0, 1'b1);
		i_power_stage_model.set(HO, 0, 1'b0);
		wt(3);
		gates(4'hB);
		chk(comp_discharge, 2'h1);
		apb(1'b0, fault_pkg::ADDR_STATUS0, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0054);
		wt(8);
		gates(4'hB);
		wt(RC);
		gates(4'hF);
		i_power_stage_model.set(LO, 1, 1'b1);
		i_power_stage_model.set(LO, 1, 1'b0);
		wt(3);
		gates(4'h5);
		chk(comp_discharge, 2'h2);
		apb(1'b0, fault_pkg::ADDR_STATUS1, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0015);
		wt(RC + 4);
		gates(4'hF);
	endtask
	task automatic t_thermal_flags();
		i_power_stage_model.set(OT, 1, 1'b1);
		wt(4);
		gates(4'h5);
		i_power_stage_model.set(OT, 1, 1'b0);
		wt(6);
		gates(4'hF);
		i_power_stage_model.set(OV, 0, 1'b1);
		i_power_stage_model.set(SH, 1, 1'b1);
		wt(3);
		chk({channel_fault_flag_n_oe_n, fault_pin}, 4'h0);
		gates(4'hF);
		i_power_stage_model.set(OV, 0, 1'b0);
		wt(3);
		chk({channel_fault_flag_n_oe_n, fault_pin}, 4'h5);
		i_power_stage_model.set(SH, 1, 1'b0);
		wt(3);
		chk(fault_pin, 2'h3);
	endtask
	task automatic t_global();
		@(posedge pclk);
		sleep_req <= 1'b1;
		wt(4);
		chk({analog_bias_connect, hs_gate_en, ls_gate_en, comp_discharge}, 7'h03);
		@(posedge pclk);
		sleep_req <= 1'b0;
		wt(8);
		gates(4'hF);
		@(posedge pclk);
		digital_bias_supply_good <= 1'b0;
		wt(4);
		chk({hs_gate_en, ls_gate_en, comp_discharge}, 6'h03);
		@(posedge pclk);
		digital_bias_supply_good <= 1'b1;
		analog_bias_supply_good <= 1'b0;
		wt(4);
		gates(4'h0);
	endtask

	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, sleep_req} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		digital_bias_supply_good = 1'b1;
		analog_bias_supply_good = 1'b1;
		fail_count = 0;
		comparisons = 0;
		repeat (5) @(posedge pclk);
		@(negedge pclk);
		chk({hs_gate_en, ls_gate_en, comp_discharge, channel_fault_flag_n_oe_n}, 8'h0F);
		@(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_input_levels();
		t_bootstrap();
		t_limits();
		t_thermal_flags();
		t_global();
		give_verdict();
	end
endmodule
`default_nettype wire
